// ---- bit_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// refuse an empty bundle
	if (WIDTH < 1) begin : g_chk
		$error("bit_sync width must be at least one");
	end

	// two flops per bit; the first is read only by the second
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic meta_reg;
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				meta_reg <= 1'b0;
				sync_out[i] <= 1'b0;
			end else begin
				meta_reg <= async_in[i];
				sync_out[i] <= meta_reg;
			end
		end
	end
endmodule
`default_nettype wire

// ---- charge_pump_mode_controller.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cpm_map.svh"
module charge_pump_mode_controller #(
	parameter int CNT_W = 27,
	parameter int unsigned POR_COUNT = `POR_CYCLES,
	parameter int unsigned SOFT_COUNT = `SOFT_START_CYCLES,
	parameter int unsigned HOLD_COUNT = `EN_HOLD_CYCLES,
	parameter int unsigned MHOLD_COUNT = `MODE_HOLD_CYCLES,
	parameter int unsigned MRESET_COUNT = `MODE_RESET_CYCLES
) (
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic ENABLE_PWM,
	input wire logic [3:0] LOW_CURRENT,
	input wire logic OT_HOT,
	input wire logic OT_COOL,
	output cpm_pkg::mode_t MODE,
	output logic LED_DRIVE,
	output logic BOOSTED_OUTPUT_EN
);
	import cpm_pkg::*;

	// synchronised pin levels
	logic [6:0] pins_s;
	logic en_s; // enable / PWM level
	logic [3:0] lc_s; // per-channel low-current flags
	logic hot_s; // above upper temperature threshold
	logic cool_s; // below lower temperature threshold

	// pins cross into the clock domain
	bit_sync #(
		.WIDTH(7)
	) u_sync (
		.clk(CLK_SYS),
		.rst_b(RST_B),
		.async_in({OT_COOL, OT_HOT, LOW_CURRENT, ENABLE_PWM}),
		.sync_out(pins_s)
	);
	assign en_s = pins_s[0];
	assign lc_s = pins_s[4:1];
	assign hot_s = pins_s[5];
	assign cool_s = pins_s[6];

	// state
	state_t state_reg, state_next; // control sequence
	mode_t mode_next; // next mode, MODE holds the current one
	logic led_reg, led_next; // LED channels allowed on
	logic en_d_reg; // enable one cycle ago
	logic lc_any_reg; // sampled OR of channel flags
	logic ot_reg, ot_next; // overtemperature shutdown latched
	logic por_go_reg; // power-on interval already launched
	logic dim_reg; // dimming-based current control in use

	// timer handshakes
	logic por_exp;
	logic ss_busy, ss_exp;
	logic hold_exp;
	logic mh_busy;
	logic mr_busy, mr_exp;

	// decoded conditions
	wire active = (state_reg == ST_SOFT) || (state_reg == ST_RUN);
	wire en_fall = en_d_reg && !en_s;
	wire in_run = (state_reg == ST_RUN);
	wire go_soft = (state_reg == ST_STANDBY) && en_s;
	wire step_ok = in_run && !mh_busy && dim_reg && lc_any_reg;
	wire mr_drop = mr_exp && in_run && (MODE != MODE_X1);
	wire active_next = (state_next == ST_SOFT) || (state_next == ST_RUN);

	// power-on interval, launched once after reset release
	interval_timer #(.CNT_W(CNT_W), .COUNT(POR_COUNT)) u_por (
		.clk(CLK_SYS),
		.rst_b(RST_B),
		.start(!por_go_reg),
		.clear(1'b0),
		.busy(),
		.expire(por_exp)
	);

	// soft start: launched only on standby exit, so toggling cannot restart it
	interval_timer #(.CNT_W(CNT_W), .COUNT(SOFT_COUNT)) u_soft (
		.clk(CLK_SYS),
		.rst_b(RST_B),
		.start(go_soft),
		.clear(!active),
		.busy(ss_busy),
		.expire(ss_exp)
	);

	// enable-low hold: reloads on every falling edge in soft start or run, dropped when enable returns
	interval_timer #(.CNT_W(CNT_W), .COUNT(HOLD_COUNT)) u_hold (
		.clk(CLK_SYS),
		.rst_b(RST_B),
		.start(active && en_fall),
		.clear(en_s || !active),
		.busy(),
		.expire(hold_exp)
	);

	// mode hold after a mode-reset step-down
	interval_timer #(.CNT_W(CNT_W), .COUNT(MHOLD_COUNT)) u_mhold (
		.clk(CLK_SYS),
		.rst_b(RST_B),
		.start(mr_drop),
		.clear(!in_run),
		.busy(mh_busy),
		.expire()
	);

	// periodic mode reset, free running while LEDs are lit
	interval_timer #(.CNT_W(CNT_W), .COUNT(MRESET_COUNT)) u_mreset (
		.clk(CLK_SYS),
		.rst_b(RST_B),
		.start(ss_exp || mr_exp),
		.clear(!in_run),
		.busy(mr_busy),
		.expire(mr_exp)
	);

	// sequence and mode stepping
	always_comb begin
		state_next = state_reg;
		mode_next = MODE;
		led_next = led_reg;
		unique case (state_reg)
			ST_POR: begin
				// wait out the power-on interval in standby
				if (por_exp) begin
					state_next = ST_STANDBY;
				end
			end
			ST_STANDBY: begin
				// enable high leaves standby, whether held or first rise
				if (en_s) begin
					state_next = ST_SOFT;
					mode_next = MODE_X15;
				end
			end
			ST_SOFT: begin
				// LEDs come on in pass-through when soft start ends
				if (ss_exp) begin
					state_next = ST_RUN;
					mode_next = MODE_X1;
					led_next = 1'b1;
				end
			end
			ST_RUN: begin
				if (mr_exp) begin
					// periodic step-down, one level only
					if (MODE == MODE_X2) begin
						mode_next = MODE_X15;
					end else if (MODE == MODE_X15) begin
						mode_next = MODE_X1;
					end
				end else if (step_ok) begin
					// one step up per evaluation
					if (MODE == MODE_X1) begin
						mode_next = MODE_X15;
					end else if (MODE == MODE_X15) begin
						mode_next = MODE_X2;
					end
				end
			end
		endcase
		// long enough low on enable returns to standby and clears mode and LEDs
		if (active && hold_exp) begin
			state_next = ST_STANDBY;
			mode_next = MODE_STANDBY;
			led_next = 1'b0;
		end
	end

	// overtemperature hysteresis: set above upper, cleared below lower
	assign ot_next = ot_reg ? !cool_s : hot_s;

	// control registers
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			state_reg <= ST_POR;
			MODE <= MODE_STANDBY;
			led_reg <= 1'b0;
			en_d_reg <= 1'b0;
			por_go_reg <= 1'b0;
			ot_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			MODE <= mode_next;
			led_reg <= led_next;
			en_d_reg <= en_s;
			por_go_reg <= 1'b1;
			ot_reg <= ot_next;
		end
	end

	// low-current flags: OR of channels, sampled, cleared outside run
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			lc_any_reg <= 1'b0;
		end else begin
			lc_any_reg <= in_run && (|lc_s);
		end
	end

	// output drivers: LED follows PWM, output stopped when hot
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			LED_DRIVE <= 1'b0;
			BOOSTED_OUTPUT_EN <= 1'b0;
		end else begin
			LED_DRIVE <= led_next && en_s;
			BOOSTED_OUTPUT_EN <= active_next && !ot_next;
		end
	end

	// register bus decode
	wire sel_ctrl = (PADDR == `REG_CTRL_ADDR);
	wire sel_stat = (PADDR == `REG_STATUS_ADDR);
	wire setup = PSEL && !PENABLE;
	wire wr_ctrl = PSEL && PENABLE && PREADY && PWRITE && sel_ctrl;
	wire [31:0] ctrl_word = {31'h00000000, dim_reg};
	wire [31:0] stat_word = {22'h000000, state_reg, 1'b0, en_s, ot_reg,
		mh_busy, ss_busy, led_reg, MODE};
	wire [31:0] rd_mux = sel_ctrl ? ctrl_word : (sel_stat ? stat_word : 32'h00000000);

	// reset word of the control register
	localparam logic [31:0] CTRL_INIT = `CTRL_RESET;

	// control register: dimming-based current control enable
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			dim_reg <= CTRL_INIT[`CTRL_DIM_BIT];
		end else if (wr_ctrl) begin
			dim_reg <= PWDATA[`CTRL_DIM_BIT];
		end
	end

	// answer in the access phase right after every setup cycle
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h00000000;
		end else begin
			PREADY <= setup;
			// unmapped addresses answer with an error and zero data
			PSLVERR <= setup && !sel_ctrl && !sel_stat;
			PRDATA <= (setup && !PWRITE) ? rd_mux : 32'h00000000;
		end
	end

	// checks
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);

	sequence s_drop_from_x2;
		mr_exp && in_run && (MODE == MODE_X2);
	endsequence
	sequence s_held_at_x15;
		(MODE == MODE_X15) && mh_busy;
	endsequence

	a_por_standby: assert property ((state_reg == ST_POR) |-> (MODE == MODE_STANDBY) && !BOOSTED_OUTPUT_EN) else $error("mode left standby during power-on interval");
	a_soft_entry: assert property (go_soft |=> (state_reg == ST_SOFT) && (MODE == MODE_X15) && !LED_DRIVE) else $error("soft start entry wrong");
	a_soft_exit: assert property ((ss_exp && state_reg == ST_SOFT && !hold_exp) |=> in_run && (MODE == MODE_X1) && led_reg) else $error("soft start exit wrong");
	a_step_x1: assert property ((step_ok && !mr_exp && !hold_exp && MODE == MODE_X1) |=> (MODE == MODE_X15)) else $error("no step to 1.5x");
	a_step_x15: assert property ((step_ok && !mr_exp && !hold_exp && MODE == MODE_X15) |=> (MODE == MODE_X2)) else $error("no step to 2x");
	a_no_dim: assert property ((in_run && !dim_reg && MODE == MODE_X1) |=> (MODE != MODE_X15) && (MODE != MODE_X2)) else $error("step-up without dimming control");
	a_reset_x15: assert property ((mr_exp && in_run && MODE == MODE_X15 && !hold_exp) |=> (MODE == MODE_X1) && mh_busy) else $error("mode reset from 1.5x wrong");
	a_reset_x2: assert property ((s_drop_from_x2 and !hold_exp) |=> s_held_at_x15) else $error("mode reset from 2x wrong");
	a_hold_freeze: assert property ((in_run && mh_busy && !hold_exp) |=> $stable(MODE)) else $error("mode changed during mode hold");
	a_standby_go: assert property ((active && hold_exp) |=> (state_reg == ST_STANDBY) && (MODE == MODE_STANDBY) && !led_reg ##1 !mh_busy && !mr_busy) else $error("standby entry did not clear state");
	a_ot_stop: assert property ((ot_reg && $past(ot_reg)) |-> !BOOSTED_OUTPUT_EN) else $error("output running while overheated");
	a_one_step: assert property ((in_run && !$past(hold_exp)) |-> (MODE == $past(MODE)) || (MODE == mode_t'($past(MODE) + 2'h1)) || (MODE == mode_t'($past(MODE) - 2'h1))) else $error("mode moved more than one step");
endmodule
`default_nettype wire

// ---- charge_pump_mode_controller_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module charge_pump_mode_controller_tb_top;
	import cpm_pkg::*;
	logic clk = 1'b0; // system clock
	logic rst_b; // power-on reset
	logic psel, pen, pwr; // apb controls
	logic [11:0] paddr; // apb address
	logic [31:0] pwdata, prdata, rd, r, seed; // bus data, random state
	logic pready, pslverr, er; // apb answer
	logic en, level_on, pwm_on, ot_hot, ot_cool, led, boost; // pins
	logic [7:0] period, high_c; // pwm shape
	logic [3:0] low_cur; // channel low-current flags
	mode_t mode; // output mode
	int num_errors = 0;
	int compares = 0;
	int cyc = 0;
	always #5 clk = ~clk;
	host_dimming_model host (.clk(clk), .rst_b(rst_b), .level_on(level_on),
		.pwm_on(pwm_on), .period(period), .high_cycles(high_c), .en(en));
	charge_pump_mode_controller #(.POR_COUNT(8), .SOFT_COUNT(40), .HOLD_COUNT(20),
		.MHOLD_COUNT(6), .MRESET_COUNT(100)) uut (.CLK_SYS(clk), .RST_B(rst_b),
		.PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ENABLE_PWM(en),
		.LOW_CURRENT(low_cur), .OT_HOT(ot_hot), .OT_COOL(ot_cool), .MODE(mode),
		.LED_DRIVE(led), .BOOSTED_OUTPUT_EN(boost));
	// xorshift random source
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// watched outputs: 0 mode, 1 boost enable, 2 led drive
	function automatic logic [31:0] obs(input int sel);
		case (sel)
			0: return {30'h0, mode};
			1: return {31'h0, boost};
			default: return {31'h0, led};
		endcase
	endfunction
	// wait at most n cycles for a value
	task automatic wait_val(input int sel, input logic [31:0] exp, input int n);
		for (int i = 0; i < n && obs(sel) !== exp; i++) @(negedge clk);
		chk(obs(sel), exp);
	endtask
	// value must stand for n cycles
	task automatic hold_val(input int sel, input logic [31:0] exp, input int n);
		logic [31:0] bad;
		bad = exp;
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			if (obs(sel) !== exp) bad = obs(sel);
		end
		chk(bad, exp);
	endtask
	// one apb transfer, held until pready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		// the answer is taken at the edge that samples pready high
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	// verdict and end of run
	task automatic close_out();
		$display("errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			num_errors++;
			close_out();
		end
	end
	// main sequence
	initial begin
		seed = 32'h43;
		{rst_b, psel, pen, pwr, pwm_on, ot_hot, low_cur} = '0;
		{paddr, pwdata} = '0;
		{level_on, ot_cool, period, high_c} = {1'b1, 1'b1, 8'h0a, 8'h07};
		repeat (6) @(posedge clk);
		chk(obs(0) | obs(1), 32'h0);
		rst_b <= 1'b1;
		hold_val(0, MODE_STANDBY, 10);
		wait_val(0, MODE_X15, 10);
		chk(obs(2), 32'h0);
		chk(obs(1), 32'h1);
		r = xs();
		@(posedge clk);
		pwm_on <= 1'b1;
		high_c <= 8'h03 + {5'h0, r[2:0]};
		hold_val(0, MODE_X15, 25);
		wait_val(0, MODE_X1, 20);
		@(posedge clk);
		pwm_on <= 1'b0;
		wait_val(2, 32'h1, 6);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h1);
		chk({31'h0, er}, 32'h0);
		r = xs();
		apb(1'b1, {1'b1, r[8:0], 2'h0}, r);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, {1'b1, r[8:0], 2'h0}, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, 12'h000, 32'hfffffffe);
		low_cur <= 4'hf;
		hold_val(0, MODE_X1, 30);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		r = xs();
		low_cur <= 4'h1 << r[1:0];
		apb(1'b1, 12'h000, 32'h1);
		wait_val(0, MODE_X15, 10);
		wait_val(0, MODE_X2, 4);
		@(posedge clk);
		low_cur <= 4'h0;
		wait_val(0, MODE_X15, 110);
		wait_val(0, MODE_X1, 110);
		@(posedge clk);
		low_cur <= 4'h8;
		hold_val(0, MODE_X1, 6);
		wait_val(0, MODE_X15, 10);
		@(posedge clk);
		low_cur <= 4'h0;
		ot_hot <= 1'b1;
		ot_cool <= 1'b0;
		wait_val(1, 32'h0, 6);
		@(posedge clk);
		ot_hot <= 1'b0;
		hold_val(1, 32'h0, 10);
		@(posedge clk);
		ot_cool <= 1'b1;
		wait_val(1, 32'h1, 6);
		@(posedge clk);
		level_on <= 1'b0;
		repeat (12) @(posedge clk);
		level_on <= 1'b1;
		hold_val(1, 32'h1, 30);
		@(posedge clk);
		level_on <= 1'b0;
		hold_val(1, 32'h1, 20);
		wait_val(0, MODE_STANDBY, 10);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h100);
		@(posedge clk);
		level_on <= 1'b1;
		wait_val(0, MODE_X15, 8);
		// reset again during soft start, this time with enable low at power-up
		@(posedge clk);
		rst_b <= 1'b0;
		level_on <= 1'b0;
		@(posedge clk);
		chk(obs(0) | obs(1), 32'h0);
		rst_b <= 1'b1;
		hold_val(0, MODE_STANDBY, 20);
		@(posedge clk);
		level_on <= 1'b1;
		wait_val(0, MODE_X15, 6);
		close_out();
	end
endmodule
`default_nettype wire

// ---- cpm_map.svh ----
`ifndef CPM_MAP_SVH
`define CPM_MAP_SVH

// clock period of CLK_SYS in ns
`define CLK_PERIOD_NS 10

// interval figures in ns
`define POR_TIME_NS 50000
`define SOFT_START_TIME_NS 1430000
`define EN_HOLD_TIME_NS 1000000
`define MODE_HOLD_MAX_NS 200000
`define MODE_RESET_TIME_NS 1000000000

// cycle counts: typical figures round up, maximum figures round down
`define POR_CYCLES ((`POR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SOFT_START_CYCLES ((`SOFT_START_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EN_HOLD_CYCLES ((`EN_HOLD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MODE_HOLD_CYCLES (`MODE_HOLD_MAX_NS / `CLK_PERIOD_NS)
`define MODE_RESET_CYCLES ((`MODE_RESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// register byte addresses
`define REG_CTRL_ADDR 12'h000
`define REG_STATUS_ADDR 12'h004

// control register fields and reset value
`define CTRL_DIM_BIT 0
`define CTRL_RESET 32'h00000001

// status register fields
`define STAT_MODE_LSB 0
`define STAT_LED_BIT 2
`define STAT_SOFT_BIT 3
`define STAT_HOLD_BIT 4
`define STAT_OT_BIT 5
`define STAT_EN_BIT 6
`define STAT_STATE_LSB 8

`endif

// ---- cpm_pkg.sv ----
package cpm_pkg;
	// output mode of the charge pump
	typedef enum logic [1:0] {
		MODE_STANDBY = 2'h0,
		MODE_X1 = 2'h1,
		MODE_X15 = 2'h2,
		MODE_X2 = 2'h3
	} mode_t;

	// control sequence state
	typedef enum logic [1:0] {
		ST_POR = 2'h0,
		ST_STANDBY = 2'h1,
		ST_SOFT = 2'h2,
		ST_RUN = 2'h3
	} state_t;
endpackage

// ---- host_dimming_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// host side of the enable pin: a steady level or a pwm wave
module host_dimming_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic level_on,
	input wire logic pwm_on,
	input wire logic [7:0] period,
	input wire logic [7:0] high_cycles,
	output logic en
);
	logic [7:0] phase_reg; // position inside the pwm period
	logic [7:0] duty_floor; // shortest high time the host allows
	// period counter, parked at zero while pwm is off
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_reg <= 8'h00;
		end else if (!pwm_on || phase_reg >= period - 8'h01) begin
			phase_reg <= 8'h00;
		end else begin
			phase_reg <= phase_reg + 8'h01;
		end
	end
	// duty never below a tenth of the period, for periods up to 246
	assign duty_floor = (period + 8'h09) / 8'h0a;
	// pin level: pwm wave or steady level
	assign en = pwm_on ? (phase_reg < high_cycles || phase_reg < duty_floor) : level_on;
endmodule
`default_nettype wire

// ---- interval_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module interval_timer #(
	parameter int CNT_W = 27,
	parameter int unsigned COUNT = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic clear,
	output logic busy,
	output logic expire
);
	// the count must fit the counter and be at least one cycle
	if (COUNT < 1 || COUNT > (64'd1 << CNT_W)) begin : g_chk
		$error("interval_timer count does not fit its counter");
	end

	localparam logic [CNT_W-1:0] LOAD = CNT_W'(COUNT - 1);

	logic [CNT_W-1:0] cnt_reg; // cycles left minus one

	// start reloads and wins over clear; expire pulses COUNT edges after start
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= '0;
			busy <= 1'b0;
			expire <= 1'b0;
		end else begin
			expire <= 1'b0;
			if (start) begin
				cnt_reg <= LOAD;
				busy <= 1'b1;
			end else if (clear) begin
				busy <= 1'b0;
			end else if (busy) begin
				if (cnt_reg == '0) begin
					busy <= 1'b0;
					expire <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg - 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire
